// ---- rtl/cssc_pkg.sv ----
// Package: constants and types for the clock source and start-up control
package cssc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FUSE_OFFSET   = 8'h08;

  // Control register field positions
  localparam int CTRL_SLEEP_EN_BIT  = 0;
  localparam int CTRL_MODE_LSB      = 1;
  localparam int CTRL_ASYNC_REQ_BIT = 4;
  localparam int CTRL_CONV_REQ_BIT  = 5;
  localparam int CTRL_SLEEP_GO_BIT  = 7;

  // Fuse and control values after reset: fuses as delivered, option fuse unprogrammed, control cleared
  localparam logic [3:0] SOURCE_SELECT_RESET = 4'h1;
  localparam logic [1:0] STARTUP_TIME_RESET  = 2'h2;
  localparam logic       OSC_OPTION_RESET    = 1'b1;
  localparam logic [7:0] CTRL_RESET          = 8'h00;

  // Start-up counts in source clock cycles
  localparam logic [15:0] STARTUP_6_CYCLES   = 16'h0006;
  localparam logic [15:0] STARTUP_18_CYCLES  = 16'h0012;
  localparam logic [15:0] STARTUP_258_CYCLES = 16'h0102;
  localparam logic [15:0] STARTUP_1K_CYCLES  = 16'h0400;

  // Short reset delay in watchdog oscillator cycles
  localparam logic [16:0] SHORT_DELAY_CYCLES = 17'h01000;

  // Reset delay selection
  typedef enum logic [1:0] {
    DELAY_NONE  = 2'b00,
    DELAY_SHORT = 2'b01,
    DELAY_LONG  = 2'b10
  } cssc_delay_type;

  // Clock source classes
  typedef enum logic [2:0] {
    SRC_EXT_CLOCK = 3'b000,
    SRC_INT_RC    = 3'b001,
    SRC_EXT_RC    = 3'b010,
    SRC_LF_XTAL   = 3'b011,
    SRC_XTAL      = 3'b100
  } cssc_source_type;

  // Sleep modes
  typedef enum logic [2:0] {
    SLEEP_IDLE       = 3'b000,
    SLEEP_CONV_NR    = 3'b001,
    SLEEP_POWER_DOWN = 3'b010,
    SLEEP_POWER_SAVE = 3'b011,
    SLEEP_STANDBY    = 3'b110
  } cssc_sleep_type;

  // Controller states
  typedef enum logic [1:0] {
    ST_RESET_DELAY = 2'b00,
    ST_STARTUP     = 2'b01,
    ST_RUN         = 2'b10,
    ST_SLEEP       = 2'b11
  } cssc_state_type;

endpackage

// ---- rtl/cssc_clock_control.sv ----
// Clock source decode, start-up timing and clock domain gating
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - Sleep mode decides which clock domains stop
// - Core clock stops all general core work
// - Peripheral clock gated; async interrupt still wakes
// - Two-wire address match wakes without peripheral clock
// - Program memory clock follows core clock
// - Async timer clock runs in idle, noise reduction and power-save sleep
// - Async timer only with internal RC source
// - Converter clock keeps running in noise reduction
// - Four-bit source select decodes five sources
// - Fuse reads one unprogrammed, zero programmed
// - Wake from power-down and power-save counts source cycles
// - Reset adds delay counted in watchdog cycles
// - Short delay 4096, long 65536 watchdog cycles
// - Delivered fuses: source 0001, start-up 10
// - Crystal range from select bits and option
// - Crystal bit0 zero start-up table
// - Crystal bit0 one start-up table
module cssc_clock_control #(
  parameter int unsigned LONG_DELAY_CYCLES = 65536,
  parameter int unsigned STARTUP_16K_CYCLES = 16384,
  parameter int unsigned STARTUP_32K_CYCLES = 32768
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] sourceSelectProgrammed,
  input  wire logic [1:0] startupTimeProgrammed,
  input  wire logic       oscOptionProgrammed,
  input  wire logic       sourceClockPin,
  input  wire logic       watchdogOscPin,
  input  wire logic       asyncInterruptPin,
  input  wire logic       twoWireAddrMatchPin,
  input  wire logic       peripheralIrq,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic [7:0]      regRdata,
  output logic            coreClockEn,
  output logic            peripheralClockEn,
  output logic            programMemoryClockEn,
  output logic            asyncTimerClockEn,
  output logic            converterClockEn,
  output logic            executionAllowed
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  function automatic cssc_pkg::cssc_source_type srcClass(
    input logic [3:0] sel
  );
    if (sel >= 4'ha) begin
      srcClass = cssc_pkg::SRC_XTAL;
    end else if (sel == 4'h9) begin
      srcClass = cssc_pkg::SRC_LF_XTAL;
    end else if (sel >= 4'h5) begin
      srcClass = cssc_pkg::SRC_EXT_RC;
    end else if (sel >= 4'h1) begin
      srcClass = cssc_pkg::SRC_INT_RC;
    end else begin
      srcClass = cssc_pkg::SRC_EXT_CLOCK;
    end
  endfunction

  // Wake-up start-up length in source cycles
  function automatic logic [15:0] startupCycles(
    input logic [3:0] sel,
    input logic [1:0] startup_time_fuses
  );
    startupCycles = cssc_pkg::STARTUP_6_CYCLES;
    case (srcClass(sel))
      cssc_pkg::SRC_XTAL: begin
        case ({sel[0], startup_time_fuses})
          3'b000, 3'b001:
            startupCycles = cssc_pkg::STARTUP_258_CYCLES;
          3'b010, 3'b011:
            startupCycles = cssc_pkg::STARTUP_1K_CYCLES;
          3'b100:
            startupCycles = cssc_pkg::STARTUP_1K_CYCLES;
          default:
            startupCycles = STARTUP_16K_CYCLES[15:0];
        endcase
      end
      cssc_pkg::SRC_LF_XTAL: begin
        if (startup_time_fuses[1]) begin
          startupCycles = STARTUP_32K_CYCLES[15:0];
        end else begin
          startupCycles = cssc_pkg::STARTUP_1K_CYCLES;
        end
      end
      cssc_pkg::SRC_EXT_RC: begin
        if (startup_time_fuses == 2'h3) begin
          startupCycles = cssc_pkg::STARTUP_6_CYCLES;
        end else begin
          startupCycles = cssc_pkg::STARTUP_18_CYCLES;
        end
      end
      default: startupCycles = cssc_pkg::STARTUP_6_CYCLES;
    endcase
  endfunction

  // Extra delay after reset
  function automatic cssc_pkg::cssc_delay_type resetDelay(
    input logic [3:0] sel,
    input logic [1:0] startup_time_fuses
  );
    resetDelay = cssc_pkg::DELAY_NONE;
    case (srcClass(sel))
      cssc_pkg::SRC_XTAL: begin
        case ({sel[0], startup_time_fuses})
          3'b000: resetDelay = cssc_pkg::DELAY_SHORT;
          3'b001: resetDelay = cssc_pkg::DELAY_LONG;
          3'b010: resetDelay = cssc_pkg::DELAY_NONE;
          3'b011: resetDelay = cssc_pkg::DELAY_SHORT;
          3'b100: resetDelay = cssc_pkg::DELAY_LONG;
          3'b101: resetDelay = cssc_pkg::DELAY_NONE;
          3'b110: resetDelay = cssc_pkg::DELAY_SHORT;
          default: resetDelay = cssc_pkg::DELAY_LONG;
        endcase
      end
      cssc_pkg::SRC_LF_XTAL: begin
        if (startup_time_fuses == 2'h0) begin
          resetDelay = cssc_pkg::DELAY_SHORT;
        end else begin
          resetDelay = cssc_pkg::DELAY_LONG;
        end
      end
      cssc_pkg::SRC_EXT_RC: begin
        case (startup_time_fuses)
          2'h0: resetDelay = cssc_pkg::DELAY_NONE;
          2'h2: resetDelay = cssc_pkg::DELAY_LONG;
          default: resetDelay = cssc_pkg::DELAY_SHORT;
        endcase
      end
      default: begin
        case (startup_time_fuses)
          2'h0: resetDelay = cssc_pkg::DELAY_NONE;
          2'h1: resetDelay = cssc_pkg::DELAY_SHORT;
          default: resetDelay = cssc_pkg::DELAY_LONG;
        endcase
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [1:0] srcSync_q;
  logic [1:0] wdtSync_q;
  logic [1:0] intSync_q;
  logic [1:0] twiSync_q;
  logic       srcPrev_q;
  logic       wdtPrev_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srcSync_q <= 2'h0;
      wdtSync_q <= 2'h0;
      intSync_q <= 2'h0;
      twiSync_q <= 2'h0;
      srcPrev_q <= 1'b0;
      wdtPrev_q <= 1'b0;
    end else begin
      srcSync_q <= {srcSync_q[0], sourceClockPin};
      wdtSync_q <= {wdtSync_q[0], watchdogOscPin};
      intSync_q <= {intSync_q[0], asyncInterruptPin};
      twiSync_q <= {twiSync_q[0], twoWireAddrMatchPin};
      srcPrev_q <= srcSync_q[1];
      wdtPrev_q <= wdtSync_q[1];
    end
  end

  logic srcTick;
  logic wdtTick;
  assign srcTick = srcSync_q[1] & ~srcPrev_q;
  assign wdtTick = wdtSync_q[1] & ~wdtPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fuse capture; reset holds the delivered values until loaded

  logic [3:0] sourceSelect_q;
  logic [1:0] startupTime_q;
  logic       oscOption_q;
  logic       fuseLoaded_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sourceSelect_q <= cssc_pkg::SOURCE_SELECT_RESET;
      startupTime_q  <= cssc_pkg::STARTUP_TIME_RESET;
      oscOption_q    <= cssc_pkg::OSC_OPTION_RESET;
      fuseLoaded_q   <= 1'b0;
    end else if (!fuseLoaded_q) begin
      // Programmed cell reads zero
      sourceSelect_q <= ~sourceSelectProgrammed;
      startupTime_q  <= ~startupTimeProgrammed;
      oscOption_q    <= ~oscOptionProgrammed;
      fuseLoaded_q   <= 1'b1;
    end
  end

  cssc_pkg::cssc_source_type srcNow;
  cssc_pkg::cssc_delay_type  delayNow;
  logic [15:0]               startupNow;
  logic [16:0]               delayTarget;
  logic [1:0]                xtalRange;

  assign srcNow     = srcClass(sourceSelect_q);
  assign delayNow   = resetDelay(sourceSelect_q, startupTime_q);
  assign startupNow = startupCycles(sourceSelect_q, startupTime_q);
  assign delayTarget = (delayNow == cssc_pkg::DELAY_LONG) ?
                       LONG_DELAY_CYCLES[16:0] :
                       cssc_pkg::SHORT_DELAY_CYCLES;
  // Range 3 means option programmed, 1 MHz and up
  assign xtalRange = !oscOption_q ? 2'h3 :
                     (sourceSelect_q[3:1] - 3'h5) >= 3'h3 ? 2'h0 :
                     2'((sourceSelect_q[3:1] - 3'h5));

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [7:0] ctrl_q;
  logic       ctrlWrite;
  logic       sleepGo;

  assign ctrlWrite = regWrite && (regAddr == cssc_pkg::CTRL_OFFSET);
  assign sleepGo   = ctrlWrite && regWdata[cssc_pkg::CTRL_SLEEP_GO_BIT]
                     && ctrl_q[cssc_pkg::CTRL_SLEEP_EN_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= cssc_pkg::CTRL_RESET;
    end else if (ctrlWrite) begin
      // Go bit is a strobe and is never stored
      ctrl_q <= {1'b0, regWdata[6:0]};
    end
  end

  cssc_pkg::cssc_sleep_type sleepMode;
  logic asyncAllowed;
  assign sleepMode = cssc_pkg::cssc_sleep_type'(
                       ctrl_q[cssc_pkg::CTRL_MODE_LSB +: 3]);
  // Shared 32 kHz oscillator pins: async timer usable only when internal RC is the chip clock
  assign asyncAllowed = ctrl_q[cssc_pkg::CTRL_ASYNC_REQ_BIT]
                        && (srcNow == cssc_pkg::SRC_INT_RC);

  ////////////////////////////////////////////////////////////////////////////
  // Start-up state machine

  cssc_pkg::cssc_state_type state_q;
  logic [16:0] count_q;
  logic        wakeEvent;

  // Pin-sensed wakes need no peripheral clock; the peripheral
  // request only counts while that domain runs
  assign wakeEvent = intSync_q[1]
                     || twiSync_q[1]
                     || (peripheralIrq && peripheralClockEn);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= cssc_pkg::ST_RESET_DELAY;
      count_q <= 17'h0;
    end else begin
      case (state_q)
        cssc_pkg::ST_RESET_DELAY: begin
          if (fuseLoaded_q) begin
            if (delayNow == cssc_pkg::DELAY_NONE) begin
              state_q <= cssc_pkg::ST_STARTUP;
              count_q <= 17'h0;
            end else if (wdtTick) begin
              if (count_q + 17'h1 >= delayTarget) begin
                state_q <= cssc_pkg::ST_STARTUP;
                count_q <= 17'h0;
              end else begin
                count_q <= count_q + 17'h1;
              end
            end
          end
        end
        cssc_pkg::ST_STARTUP: begin
          if (srcTick) begin
            if (count_q + 17'h1 >= {1'b0, startupNow}) begin
              state_q <= cssc_pkg::ST_RUN;
              count_q <= 17'h0;
            end else begin
              count_q <= count_q + 17'h1;
            end
          end
        end
        cssc_pkg::ST_RUN: begin
          if (sleepGo) begin
            state_q <= cssc_pkg::ST_SLEEP;
          end
        end
        cssc_pkg::ST_SLEEP: begin
          if (wakeEvent) begin
            count_q <= 17'h0;
            // Oscillator was stopped, so let it settle again
            if (sleepMode == cssc_pkg::SLEEP_POWER_DOWN ||
                sleepMode == cssc_pkg::SLEEP_POWER_SAVE) begin
              state_q <= cssc_pkg::ST_STARTUP;
            end else begin
              state_q <= cssc_pkg::ST_RUN;
            end
          end
        end
        default: state_q <= cssc_pkg::ST_RESET_DELAY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock domain enables, computed from the next state (from the current state when start-up ends)

  logic coreEnD;
  logic periphEnD;
  logic asyncEnD;
  logic convEnD;
  logic goingSleep;

  assign goingSleep = (state_q == cssc_pkg::ST_SLEEP && !wakeEvent)
                      || (state_q == cssc_pkg::ST_RUN && sleepGo);

  always_comb begin
    coreEnD   = 1'b0;
    periphEnD = 1'b0;
    asyncEnD  = 1'b0;
    convEnD   = 1'b0;
    if (goingSleep) begin
      case (sleepMode)
        cssc_pkg::SLEEP_CONV_NR: begin
          convEnD  = 1'b1;
          asyncEnD = asyncAllowed;
        end
        cssc_pkg::SLEEP_POWER_SAVE: asyncEnD = asyncAllowed;
        cssc_pkg::SLEEP_POWER_DOWN: asyncEnD = 1'b0;
        cssc_pkg::SLEEP_STANDBY:    asyncEnD = 1'b0;
        default: begin
          periphEnD = 1'b1;
          convEnD   = ctrl_q[cssc_pkg::CTRL_CONV_REQ_BIT];
          asyncEnD  = asyncAllowed;
        end
      endcase
    end else if (state_q == cssc_pkg::ST_RUN ||
                 (state_q == cssc_pkg::ST_SLEEP &&
                  sleepMode != cssc_pkg::SLEEP_POWER_DOWN &&
                  sleepMode != cssc_pkg::SLEEP_POWER_SAVE)) begin
      coreEnD   = 1'b1;
      periphEnD = 1'b1;
      convEnD   = ctrl_q[cssc_pkg::CTRL_CONV_REQ_BIT];
      asyncEnD  = asyncAllowed;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      coreClockEn          <= 1'b0;
      programMemoryClockEn <= 1'b0;
      peripheralClockEn    <= 1'b0;
      asyncTimerClockEn    <= 1'b0;
      converterClockEn     <= 1'b0;
      executionAllowed     <= 1'b0;
    end else begin
      coreClockEn          <= coreEnD;
      programMemoryClockEn <= coreEnD;
      peripheralClockEn    <= periphEnD;
      asyncTimerClockEn    <= asyncEnD;
      converterClockEn     <= convEnD;
      executionAllowed     <= coreEnD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        cssc_pkg::CTRL_OFFSET:   regRdata <= ctrl_q;
        cssc_pkg::STATUS_OFFSET: regRdata <= {asyncAllowed, xtalRange,
                                              srcNow, state_q};
        cssc_pkg::FUSE_OFFSET:   regRdata <= {1'b0, oscOption_q,
                                              startupTime_q,
                                              sourceSelect_q};
        default:                 regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule // cssc_clock_control

// ---- tb/cssc_osc_model.sv ----
// Partner model: free-running source and watchdog oscillators
`timescale 1ns/10ps
module cssc_osc_model #(
  parameter real SOURCE_HALF   = 10.0,
  parameter real WATCHDOG_HALF = 10.0
) (
  output logic sourceClock,
  output logic watchdogOsc
);
  ////////////////////////////////////////////////////////////////////////////
  // Odd start offsets keep both edges away from the sampling clock edge
  initial begin
    sourceClock = 1'b0;
    #1.3;
    forever #(SOURCE_HALF) sourceClock = ~sourceClock;
  end
  initial begin
    watchdogOsc = 1'b0;
    #3.7;
    forever #(WATCHDOG_HALF) watchdogOsc = ~watchdogOsc;
  end
endmodule  // cssc_osc_model

// ---- tb/cssc_clock_control_assertions.sv ----
// Checker: concurrent assertions on the clock control ports
`timescale 1ns/10ps
module cssc_clock_control_assertions #(
  parameter int unsigned LONG_DELAY_CYCLES  = 65536,
  parameter int unsigned STARTUP_16K_CYCLES = 16384,
  parameter int unsigned STARTUP_32K_CYCLES = 32768
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] sourceSelectProgrammed,
  input wire logic [1:0] startupTimeProgrammed,
  input wire logic       oscOptionProgrammed,
  input wire logic       sourceClockPin,
  input wire logic       watchdogOscPin,
  input wire logic       asyncInterruptPin,
  input wire logic       twoWireAddrMatchPin,
  input wire logic       peripheralIrq,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       coreClockEn,
  input wire logic       peripheralClockEn,
  input wire logic       programMemoryClockEn,
  input wire logic       asyncTimerClockEn,
  input wire logic       converterClockEn,
  input wire logic       executionAllowed
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] selFuse;
  logic       intRc;
  logic       ctrlWr;
  logic       fuseRd;
  logic       statRd;
  logic       goSleep;
  logic [7:0] ctrl_q;
  assign selFuse = ~sourceSelectProgrammed;
  assign intRc   = selFuse inside {[4'h1:4'h4]};
  assign ctrlWr  = regWrite && regAddr == cssc_pkg::CTRL_OFFSET;
  assign fuseRd  = regRead && regAddr == cssc_pkg::FUSE_OFFSET;
  assign statRd  = regRead && regAddr == cssc_pkg::STATUS_OFFSET;
  // Sleep-go counts only once the stored enable bit is already set
  assign goSleep = ctrlWr && regWdata[7] && regWdata[0] && ctrl_q[0]
                   && executionAllowed;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 8'h00;
    end else if (ctrlWr) begin
      ctrl_q <= regWdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  exec_core_a: assert property (executionAllowed == coreClockEn)
    else $error("execution flag differs from core clock");
  flash_core_a: assert property (programMemoryClockEn == coreClockEn)
    else $error("program memory clock not tied to core clock");
  rdata_idle_a: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  fuse_read_a: assert property (fuseRd |=> regRdata == {1'b0,
    ~oscOptionProgrammed, ~startupTimeProgrammed, selFuse})
    else $error("fuse register not the inverse of programmed cells");
  async_status_a: assert property (statRd |=> regRdata[7] ==
    (intRc && ctrl_q[4]))
    else $error("async allowed flag wrong for source");
  async_source_a: assert property (asyncTimerClockEn |-> intRc)
    else $error("async timer clock runs without internal RC");
  sleep_core_a: assert property (goSleep |-> ##[1:3] !coreClockEn)
    else $error("core clock still running after sleep-go");
  sleep_refused_a: assert property (ctrlWr && regWdata[7]
    && !ctrl_q[0] && executionAllowed |=> executionAllowed [*3])
    else $error("sleep-go taken without stored enable");
  deep_off_a: assert property (goSleep && regWdata[2:1] == 2'b10
    |-> ##3 !(peripheralClockEn || asyncTimerClockEn || converterClockEn))
    else $error("domain clock running in deep sleep");
  noise_conv_a: assert property (goSleep && regWdata[3:1] == 3'h1
    |-> ##3 converterClockEn && !peripheralClockEn)
    else $error("noise reduction sleep gating wrong");
  idle_periph_a: assert property (goSleep && regWdata[3:1] == 3'h0
    |-> ##3 peripheralClockEn && !coreClockEn)
    else $error("idle sleep gating wrong");
  ////////////////////////////////////////////////////////////////////////////
  sleep_c: cover property (goSleep);
  wake_c: cover property ($rose(executionAllowed));
  fuse_c: cover property (fuseRd);
endmodule  // cssc_clock_control_assertions

bind cssc_clock_control cssc_clock_control_assertions #(
  .LONG_DELAY_CYCLES  (LONG_DELAY_CYCLES),
  .STARTUP_16K_CYCLES (STARTUP_16K_CYCLES),
  .STARTUP_32K_CYCLES (STARTUP_32K_CYCLES)
) cssc_clock_control_assertions_i (
  .mclk, .rst, .sourceSelectProgrammed, .startupTimeProgrammed,
  .oscOptionProgrammed, .sourceClockPin, .watchdogOscPin,
  .asyncInterruptPin, .twoWireAddrMatchPin, .peripheralIrq, .regAddr,
  .regWdata, .regWrite, .regRead, .regRdata, .coreClockEn,
  .peripheralClockEn, .programMemoryClockEn, .asyncTimerClockEn,
  .converterClockEn, .executionAllowed
);

// ---- tb/clock_source_startup_control_test.sv ----
// Testbench: fuse decode table, start-up timing and sleep gating
`timescale 1ns/10ps
module clock_source_startup_control_test;
  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] startup_time_fuses;
    logic       opt;
    int         dly;
    int         cyc;
    logic [2:0] cls;
    logic [1:0] rng;
  } cssc_row_type;
  logic       mclk                   = 1'b0;
  logic       rst                    = 1'b1;
  logic [3:0] sourceSelectProgrammed = 4'h0;
  logic [1:0] startupTimeProgrammed  = 2'h0;
  logic       oscOptionProgrammed    = 1'b0;
  logic       sourceClockPin;
  logic       watchdogOscPin;
  logic       asyncInterruptPin      = 1'b0;
  logic       twoWireAddrMatchPin    = 1'b0;
  logic       peripheralIrq          = 1'b0;
  logic [7:0] regAddr                = 8'h00;
  logic [7:0] regWdata               = 8'h00;
  logic       regWrite               = 1'b0;
  logic       regRead                = 1'b0;
  logic [7:0] regRdata;
  logic       coreClockEn;
  logic       peripheralClockEn;
  logic       programMemoryClockEn;
  logic       asyncTimerClockEn;
  logic       converterClockEn;
  logic       executionAllowed;
  logic [7:0] ens;
  int         miscompares            = 0;
  int         compares               = 0;
  int         cycles                 = 0;
  // Fuse values, delay and start-up counts, source class, crystal range
  // Low ranges and 258-cycle rows stand for a ceramic resonator
  cssc_row_type rows [14] = '{
    '{4'h1, 2'h2, 1'b1, 64, 6, 3'h1, 2'h0},
    '{4'hf, 2'h3, 1'b1, 64, 40, 3'h4, 2'h2},
    '{4'ha, 2'h0, 1'b1, 4096, 258, 3'h4, 2'h0},
    '{4'hc, 2'h2, 1'b1, 0, 1024, 3'h4, 2'h1},
    '{4'hc, 2'h3, 1'b1, 4096, 1024, 3'h4, 2'h1},
    '{4'hb, 2'h1, 1'b0, 0, 40, 3'h4, 2'h3},
    '{4'he, 2'h1, 1'b1, 64, 258, 3'h4, 2'h2},
    '{4'hd, 2'h0, 1'b1, 64, 1024, 3'h4, 2'h1},
    '{4'hb, 2'h2, 1'b1, 4096, 40, 3'h4, 2'h0},
    '{4'h9, 2'h2, 1'b1, 64, 48, 3'h3, 2'h0},
    '{4'h8, 2'h2, 1'b1, 64, 18, 3'h2, 2'h0},
    '{4'h5, 2'h0, 1'b1, 0, 18, 3'h2, 2'h0},
    '{4'h0, 2'h0, 1'b1, 0, 6, 3'h0, 2'h0},
    '{4'h4, 2'h0, 1'b1, 0, 6, 3'h1, 2'h0}};
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  assign ens = {3'h0, coreClockEn, programMemoryClockEn, peripheralClockEn,
                asyncTimerClockEn, converterClockEn};
  always #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  cssc_osc_model cssc_osc_model_i (
    .sourceClock (sourceClockPin),
    .watchdogOsc (watchdogOscPin)
  );
  // Shortened long counts keep the run brief; expectations use these
  cssc_clock_control #(
    .LONG_DELAY_CYCLES  (64),
    .STARTUP_16K_CYCLES (40),
    .STARTUP_32K_CYCLES (48)
  ) cssc_clock_control_i (
    .mclk, .rst, .sourceSelectProgrammed, .startupTimeProgrammed,
    .oscOptionProgrammed, .sourceClockPin, .watchdogOscPin,
    .asyncInterruptPin, .twoWireAddrMatchPin, .peripheralIrq, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .coreClockEn,
    .peripheralClockEn, .programMemoryClockEn, .asyncTimerClockEn,
    .converterClockEn, .executionAllowed
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Both oscillators run free, so a start can land up to a period late
  task automatic chkWin(input int got, input int exp);
    compares++;
    if (got < exp - 4 || got > exp + 20) begin
      miscompares++;
      $display("MISMATCH %0t took %0d cycles not %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk8(regRdata, exp);
    @(posedge mclk);
    #1 chk8(regRdata, 8'h00);
  endtask
  task automatic doReset(input cssc_row_type r);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    sourceSelectProgrammed <= ~r.sel;
    startupTimeProgrammed <= ~r.startup_time_fuses;
    oscOptionProgrammed <= ~r.opt;
    repeat (18) @(posedge mclk);
    #1 chk8(ens | {executionAllowed, 7'h0}, 8'h00);
    @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic waitRun(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (executionAllowed !== 1'b1 && n < 30000);
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [7:0] m;
    logic idle;
    foreach (rows[i]) begin
      doReset(rows[i]);
      waitRun(n);
      chkWin(n, 4 * (rows[i].dly + rows[i].cyc));
      rdChk(8'h08, {1'b0, rows[i].opt, rows[i].startup_time_fuses, rows[i].sel});
      wr(8'h00, 8'h10);
      rdChk(8'h04, {rows[i].cls == 3'h1, rows[i].rng, rows[i].cls,
                    2'h2});
    end
    doReset(rows[0]);
    waitRun(n);
    wr(8'h00, 8'h80);
    repeat (3) @(posedge mclk);
    #1 chk8({7'h0, executionAllowed}, 8'h01);
    wr(8'h00, 8'h41);
    wr(8'h0c, 8'hff);
    wr(8'h08, 8'h00);
    rdChk(8'h00, 8'h41);
    rdChk(8'h0c, 8'h00);
    rdChk(8'h08, 8'h61);
    foreach (modes[k]) begin
      m = {4'h3, modes[k], 1'b1};
      idle = modes[k] == 3'h0;
      wr(8'h00, m);
      wr(8'h00, m | 8'h80);
      repeat (4) @(posedge mclk);
      #1 chk8(ens, {5'h0, idle, modes[k] inside {3'h0, 3'h1, 3'h3},
                    modes[k] inside {3'h0, 3'h1}});
      @(posedge mclk);
      peripheralIrq <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 chk8({7'h0, executionAllowed}, {7'h0, idle});
      @(posedge mclk);
      peripheralIrq <= 1'b0;
      twoWireAddrMatchPin <= modes[k][1] && !modes[k][0];
      asyncInterruptPin <= !(modes[k][1] && !modes[k][0]);
      waitRun(n);
      chkWin(n, modes[k][1:0] == 2'h2 || modes[k] == 3'h3 ?
             (modes[k][2] ? 0 : 24) : 0);
      @(posedge mclk);
      asyncInterruptPin <= 1'b0;
      twoWireAddrMatchPin <= 1'b0;
    end
    doReset(rows[1]);
    repeat (100) @(posedge mclk);
    doReset(rows[12]);
    waitRun(n);
    chkWin(n, 24);
    stop_test();
  end
endmodule  // clock_source_startup_control_test
